// ===== core/pll_div_ctrl.sv
// Purpose: digital control of a parallel-load synthesiser loop
// Assumes: rfIn and refIn are sampled levels slower than half of clk_sys
// Notes: analog pump, preamp and oscillator sit outside; pump shown as levels
// Functional notes
// - rf buffer transparent on strobe, else holds
// - unconnected rf word bits read high
// - strobe high resets counters, disables pump
// - strobe low loads buffers into counters, gain
// - strobe low runs counters, pump compares phases
// - gain select buffered like rf word
// - output enable gates both monitor outputs
// - sense high: sink when rf leads
// - sense low inverts sink and source
// - monitor outputs swap roles with sense
// - rf pulse every M*N+A, eight cycles wide
// - reference pulse every R, high-phase wide
// - ten strap inputs give reference ratio
// - lock sink enabled while loop locked
// - prescaler, swallow and main counters
// - gain picks factor 1, 1.5, 2.5, 4
`timescale 1ns/10ps
`default_nettype none
module pll_div_ctrl
  import pll_div_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // parallel load bus
  input wire logic loadStrobe,
  input wire logic [RF_WORD_W-1:0] rfWord,
  input wire logic [GAIN_W-1:0] pumpGainSelect,
  // hard-wired straps
  input wire logic [REF_W-1:0] refRatio,
  input wire logic dividedOutputEnable,
  input wire logic loopSense,
  // divider inputs
  input wire logic rfIn,
  input wire logic refIn,
  // monitor outputs
  output logic monitorA,
  output logic monitorB,
  // pump control
  output logic pumpSink,
  output logic pumpSource,
  output logic [GAIN_W-1:0] pumpGain,
  output logic [5:0] pumpFactorX10,
  // lock indicator
  output logic lockSink
);

  // edge detection of the signal inputs
  logic rfInPrev_r;
  logic refInPrev_r;
  logic rfRise;
  logic refRise;
  logic refFall;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rfInPrev_r <= 1'b0;
      refInPrev_r <= 1'b0;
    end else begin
      rfInPrev_r <= rfIn;
      refInPrev_r <= refIn;
    end
  end

  assign rfRise = rfIn && !rfInPrev_r;
  assign refRise = refIn && !refInPrev_r;
  assign refFall = !refIn && refInPrev_r;

  // input buffers and gain control
  logic [RF_WORD_W-1:0] rfBuf_r;
  logic [RF_WORD_W-1:0] rfBuf_nxt;
  logic [GAIN_W-1:0] gainBuf_r;
  logic [GAIN_W-1:0] gainBuf_nxt;
  logic [GAIN_W-1:0] gainCtl_r;
  logic [GAIN_W-1:0] gainCtl_nxt;
  logic [5:0] factor_r;
  logic [5:0] factor_nxt;

  always_comb begin
    rfBuf_nxt = loadStrobe ? rfWord : rfBuf_r;
    gainBuf_nxt = loadStrobe ? pumpGainSelect : gainBuf_r;
    gainCtl_nxt = loadStrobe ? gainCtl_r : gainBuf_r;
    unique case (gainCtl_nxt)
      2'h0: factor_nxt = FACTOR_X10_G0;
      2'h1: factor_nxt = FACTOR_X10_G1;
      2'h2: factor_nxt = FACTOR_X10_G2;
      2'h3: factor_nxt = FACTOR_X10_G3;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rfBuf_r <= RF_WORD_RST;
      gainBuf_r <= GAIN_RST;
      gainCtl_r <= GAIN_RST;
      factor_r <= FACTOR_X10_G3;
    end else begin
      rfBuf_r <= rfBuf_nxt;
      gainBuf_r <= gainBuf_nxt;
      gainCtl_r <= gainCtl_nxt;
      factor_r <= factor_nxt;
    end
  end

  assign pumpGain = gainCtl_r;
  assign pumpFactorX10 = factor_r;

  logic rfPulse;
  rf_divider u_rf_divider (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .hold(loadStrobe),
    .rfRise(rfRise),
    .swallowRatio(rfBuf_r[SWALLOW_LSB +: SWALLOW_W]),
    .mainRatio(rfBuf_r[MAIN_LSB +: MAIN_W]),
    .divPulse(rfPulse)
  );

  // reference divider
  logic [REF_W-1:0] refCnt_r;
  logic [REF_W-1:0] refCnt_nxt;
  logic refPulse_r;
  logic refPulse_nxt;

  always_comb begin
    refCnt_nxt = refCnt_r;
    refPulse_nxt = refPulse_r;
    if (loadStrobe) begin
      refCnt_nxt = '0;
      refPulse_nxt = 1'b0;
    end else if (refRise) begin
      if (refCnt_r == refRatio - 10'h001) begin
        refCnt_nxt = '0;
        refPulse_nxt = 1'b1;
      end else begin
        refCnt_nxt = refCnt_r + 10'h001;
      end
    end else if (refFall) begin
      refPulse_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      refCnt_r <= '0;
      refPulse_r <= 1'b0;
    end else begin
      refCnt_r <= refCnt_nxt;
      refPulse_r <= refPulse_nxt;
    end
  end

  logic rfPulsePrev_r;
  logic refPulsePrev_r;
  logic rfLead_r;
  logic rfLead_nxt;
  logic refLead_r;
  logic refLead_nxt;
  pump_s pump_r;
  pump_s pump_nxt;
  logic rfEvent;
  logic refEvent;

  assign rfEvent = rfPulse && !rfPulsePrev_r;
  assign refEvent = refPulse_r && !refPulsePrev_r;

  always_comb begin
    rfLead_nxt = rfLead_r || rfEvent;
    refLead_nxt = refLead_r || refEvent;
    if (rfLead_nxt && refLead_nxt) begin
      rfLead_nxt = 1'b0;
      refLead_nxt = 1'b0;
    end
    if (loadStrobe) begin
      rfLead_nxt = 1'b0;
      refLead_nxt = 1'b0;
    end
    pump_nxt.sink = loopSense ? rfLead_nxt : refLead_nxt;
    pump_nxt.source = loopSense ? refLead_nxt : rfLead_nxt;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rfPulsePrev_r <= 1'b0;
      refPulsePrev_r <= 1'b0;
      rfLead_r <= 1'b0;
      refLead_r <= 1'b0;
      pump_r <= '0;
    end else begin
      rfPulsePrev_r <= rfPulse;
      refPulsePrev_r <= refPulse_r;
      rfLead_r <= rfLead_nxt;
      refLead_r <= refLead_nxt;
      pump_r <= pump_nxt;
    end
  end

  assign pumpSink = pump_r.sink;
  assign pumpSource = pump_r.source;

  // monitor outputs
  logic monA_r;
  logic monA_nxt;
  logic monB_r;
  logic monB_nxt;

  always_comb begin
    monA_nxt = dividedOutputEnable && (loopSense ? rfPulse : refPulse_r);
    monB_nxt = dividedOutputEnable && (loopSense ? refPulse_r : rfPulse);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      monA_r <= 1'b0;
      monB_r <= 1'b0;
    end else begin
      monA_r <= monA_nxt;
      monB_r <= monB_nxt;
    end
  end

  assign monitorA = monA_r;
  assign monitorB = monB_r;

  // lock detection: count quiet comparisons
  logic [3:0] actCnt_r;
  logic [3:0] actCnt_nxt;
  logic [3:0] lockCnt_r;
  logic [3:0] lockCnt_nxt;
  logic lock_r;
  logic lock_nxt;

  always_comb begin
    actCnt_nxt = actCnt_r;
    lockCnt_nxt = lockCnt_r;
    if (loadStrobe) begin
      actCnt_nxt = 4'h0;
      lockCnt_nxt = 4'h0;
    end else if (refEvent) begin
      actCnt_nxt = 4'h0;
      if (actCnt_r > LOCK_ACTIVE_MAX) begin
        lockCnt_nxt = 4'h0;
      end else if (lockCnt_r != LOCK_EVENTS) begin
        lockCnt_nxt = lockCnt_r + 4'h1;
      end
    end else if ((pump_r.sink || pump_r.source) && actCnt_r != 4'hf) begin
      actCnt_nxt = actCnt_r + 4'h1;
    end
    lock_nxt = (lockCnt_nxt == LOCK_EVENTS);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      actCnt_r <= 4'h0;
      lockCnt_r <= 4'h0;
      lock_r <= 1'b0;
    end else begin
      actCnt_r <= actCnt_nxt;
      lockCnt_r <= lockCnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign lockSink = lock_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence strobeRelease;
    $fell(loadStrobe) ##1 !loadStrobe;
  endsequence

  chk_buffer_follows: assert property (
    loadStrobe |=> rfBuf_r == $past(rfWord))
    else $error("rf buffer did not follow the bus while strobe high");

  chk_buffer_frozen: assert property (
    !loadStrobe |=> $stable(rfBuf_r) && $stable(gainBuf_r))
    else $error("buffers changed while strobe low");

  chk_strobe_quiet: assert property (
    loadStrobe |=> !pumpSink && !pumpSource && refCnt_r == '0)
    else $error("pump or reference counter active under strobe");

  chk_gain_loaded: assert property (
    strobeRelease |-> pumpGain == $past(gainBuf_r))
    else $error("gain control not loaded from frozen buffer");

  chk_pump_exclusive: assert property (
    !(pumpSink && pumpSource))
    else $error("pump sinks and sources together");

  chk_sense_direction: assert property (
    !loadStrobe && loopSense && rfEvent && !refLead_r && !refEvent |=> pumpSink && !pumpSource)
    else $error("pump direction wrong for rf lead");

  chk_monitor_off: assert property (
    !dividedOutputEnable |=> !monitorA && !monitorB)
    else $error("monitor outputs driven while disabled");

  chk_monitor_swap: assert property (
    dividedOutputEnable && !loopSense |=> monitorA == $past(refPulse_r) && monitorB == $past(rfPulse))
    else $error("monitor roles not swapped for low sense");

  chk_ref_width: assert property (
    !loadStrobe && refFall |=> !refPulse_r)
    else $error("reference pulse outlived the high phase");

  chk_no_early_pump: assert property (
    strobeRelease ##0 (!rfEvent && !refEvent)[*2] |-> !pumpSink && !pumpSource)
    else $error("pump active before first divided pulse");

endmodule // pll_div_ctrl
`default_nettype wire

// ===== core/pll_div_pkg.sv
// Purpose: shared constants and types for the synthesiser divider control
// Assumes: one system clock; rf and reference inputs arrive as sampled levels
// Notes: dual-modulus prescaler of 8/9, so the rf word splits 3 + 11 bits
package pll_div_pkg;

  // field widths of the parallel word and the straps
  localparam int RF_WORD_W = 14;
  localparam int SWALLOW_W = 3;
  localparam int MAIN_W = 11;
  localparam int REF_W = 10;
  localparam int GAIN_W = 2;

  // field positions inside the rf divide word
  localparam int SWALLOW_LSB = 0;
  localparam int MAIN_LSB = 3;

  // prescaler terminal counts for divide-by-8 and divide-by-9
  localparam logic [3:0] PSC_LAST_LOW = 4'h7;
  localparam logic [3:0] PSC_LAST_HIGH = 4'h8;
  // rf cycles per divided pulse: one low-modulus prescaler period
  localparam logic [3:0] RF_PULSE_CYCLES = 4'h8;

  // values after reset: inputs that float read as high
  localparam logic [RF_WORD_W-1:0] RF_WORD_RST = 14'h3fff;
  localparam logic [GAIN_W-1:0] GAIN_RST = 2'h3;

  // pump current multiplication factors, scaled by ten
  localparam logic [5:0] FACTOR_X10_G0 = 6'h0a;
  localparam logic [5:0] FACTOR_X10_G1 = 6'h0f;
  localparam logic [5:0] FACTOR_X10_G2 = 6'h19;
  localparam logic [5:0] FACTOR_X10_G3 = 6'h28;

  // lock detection: pump cycles tolerated per comparison, good comparisons needed
  localparam logic [3:0] LOCK_ACTIVE_MAX = 4'h4;
  localparam logic [3:0] LOCK_EVENTS = 4'ha;

  typedef struct packed {
    logic sink;
    logic source;
  } pump_s;

  typedef struct packed {
    logic [3:0] psc;
    logic [SWALLOW_W-1:0] swallow;
    logic [MAIN_W-1:0] main;
  } rf_count_s;

endpackage

// ===== core/rf_divider.sv
// Purpose: rf divide chain of prescaler, swallow counter and main counter
// Assumes: rfRise is a one-cycle pulse per rf input cycle; swallow below main
// Notes: ratio is main*8 + swallow; output high for the final prescaler period
`timescale 1ns/10ps
`default_nettype none
module rf_divider
  import pll_div_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control
  input wire logic hold,
  input wire logic rfRise,
  input wire logic [SWALLOW_W-1:0] swallowRatio,
  input wire logic [MAIN_W-1:0] mainRatio,
  // divided output
  output logic divPulse
);

  rf_count_s cnt_r;
  rf_count_s cnt_nxt;
  logic divPulse_r;
  logic divPulse_nxt;
  logic [3:0] pscLast;
  logic [MAIN_W-1:0] mainLast;

  assign mainLast = mainRatio - 11'h001;
  assign divPulse = divPulse_r;

  always_comb begin
    cnt_nxt = cnt_r;
    pscLast = (cnt_r.swallow < swallowRatio) ? PSC_LAST_HIGH : PSC_LAST_LOW;
    if (hold) begin
      cnt_nxt = '0;
    end else if (rfRise) begin
      if (cnt_r.psc == pscLast) begin
        cnt_nxt.psc = 4'h0;
        if (cnt_r.main == mainLast) begin
          cnt_nxt.main = '0;
          cnt_nxt.swallow = '0;
        end else begin
          cnt_nxt.main = cnt_r.main + 11'h001;
          if (cnt_r.swallow < swallowRatio) begin
            cnt_nxt.swallow = cnt_r.swallow + 3'h1;
          end
        end
      end else begin
        cnt_nxt.psc = cnt_r.psc + 4'h1;
      end
    end
    divPulse_nxt = !hold && (cnt_nxt.main == mainLast);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      divPulse_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      divPulse_r <= divPulse_nxt;
    end
  end

  // rf edges seen while the pulse stands
  logic [3:0] widthCnt_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      widthCnt_r <= 4'h0;
    end else if (!divPulse_r) begin
      widthCnt_r <= 4'h0;
    end else if (rfRise) begin
      widthCnt_r <= widthCnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_pulse_width: assert property (
    $fell(divPulse_r) && !$past(hold) && !hold && mainRatio > 11'h001
      |-> widthCnt_r == RF_PULSE_CYCLES)
    else $error("rf divided pulse width is not eight rf cycles");

  chk_hold_clears: assert property (
    hold |=> cnt_r == '0 && !divPulse_r)
    else $error("rf counters not cleared while held");

  chk_modulus_nine: assert property (
    !hold && rfRise && cnt_r.psc == PSC_LAST_LOW && cnt_r.swallow < swallowRatio
      |=> cnt_r.psc == PSC_LAST_HIGH)
    else $error("prescaler left divide by nine early");

endmodule // rf_divider
`default_nettype wire

// ===== dv/rf_ref_source.sv
// Purpose: far-side model making the rf and reference input levels
// Assumes: each level lasts at least two clk_sys cycles
// Notes: square waves run free unless stopped; a stop parks the level low so a restart has known phase
`timescale 1ns/10ps
`default_nettype none
module rf_ref_source (
  // clock
  input wire logic clk_sys,
  // run enables: low stops a source at level low
  input wire logic rfRun,
  input wire logic refRun,
  // half periods in clk_sys cycles
  input wire logic [7:0] rfHalf,
  input wire logic [7:0] refHalf,
  // oscillator levels
  output logic rfIn,
  output logic refIn
);
  logic [7:0] rfCnt = 8'h00;
  logic [7:0] refCnt = 8'h00;
  logic rfLvl = 1'b0;
  logic refLvl = 1'b0;

  assign rfIn = rfLvl;
  assign refIn = refLvl;

  always @(posedge clk_sys) begin
    if (!rfRun) begin
      rfCnt <= 8'h00;
      rfLvl <= 1'b0;
    end else if (rfCnt + 8'h01 >= rfHalf) begin
      rfCnt <= 8'h00;
      rfLvl <= ~rfLvl;
    end else begin
      rfCnt <= rfCnt + 8'h01;
    end
    if (!refRun) begin
      refCnt <= 8'h00;
      refLvl <= 1'b0;
    end else if (refCnt + 8'h01 >= refHalf) begin
      refCnt <= 8'h00;
      refLvl <= ~refLvl;
    end else begin
      refCnt <= refCnt + 8'h01;
    end
  end
endmodule // rf_ref_source
`default_nettype wire

// ===== dv/tb_pll_div_ctrl.sv
// Purpose: self-checking bench for the parallel-load divider control
// Assumes: rf period 4 clocks, reference period 6 clocks, R strapped to 5, later 44
// Notes: rf word M=7 A=3 gives 59 rf cycles, 236 clocks per divided pulse
`timescale 1ns/10ps
`default_nettype none
module tb_pll_div_ctrl;
  import pll_div_pkg::*;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic loadStrobe = 1'b0;
  logic [RF_WORD_W-1:0] rfWord = 14'h0000;
  logic [GAIN_W-1:0] pumpGainSelect = 2'h0;
  logic [REF_W-1:0] refRatio = 10'h005;
  logic dividedOutputEnable = 1'b1;
  logic loopSense = 1'b1;
  logic rfRun = 1'b1;
  logic refRun = 1'b1;
  logic rfIn;
  logic refIn;
  logic monitorA;
  logic monitorB;
  logic pumpSink;
  logic pumpSource;
  logic [GAIN_W-1:0] pumpGain;
  logic [5:0] pumpFactorX10;
  logic lockSink;
  int err_total = 0;
  int checks_done = 0;
  int per;
  int wid;
  logic seenAny;
  logic [1:0] pumpSeen;
  logic [5:0] factorExp [4] = '{6'h0a, 6'h0f, 6'h19, 6'h28};

  always #2 clk_sys = ~clk_sys;

  pll_div_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .loadStrobe(loadStrobe),
    .rfWord(rfWord), .pumpGainSelect(pumpGainSelect), .refRatio(refRatio),
    .dividedOutputEnable(dividedOutputEnable), .loopSense(loopSense), .rfIn(rfIn),
    .refIn(refIn), .monitorA(monitorA), .monitorB(monitorB), .pumpSink(pumpSink),
    .pumpSource(pumpSource), .pumpGain(pumpGain), .pumpFactorX10(pumpFactorX10),
    .lockSink(lockSink));

  rf_ref_source src (.clk_sys(clk_sys), .rfRun(rfRun), .refRun(refRun), .rfHalf(8'h02),
    .refHalf(8'h03), .rfIn(rfIn), .refIn(refIn));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic load(input logic [RF_WORD_W-1:0] w, input logic [GAIN_W-1:0] g);
    @(posedge clk_sys);
    rfWord <= w;
    pumpGainSelect <= g;
    loadStrobe <= 1'b1;
    repeat (2) @(posedge clk_sys);
    loadStrobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  function automatic logic mon(input logic useB);
    return useB ? monitorB : monitorA;
  endfunction

  task automatic wait_level(input logic useB, input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (mon(useB) !== lvl && n < 4000);
    if (n >= 4000) begin
      check("monitor wait", 16'h0000, 16'h0001);
    end
  endtask

  // period and high time of one monitor output, in clocks
  task automatic measure(input logic useB, output int p, output int w);
    int n;
    wait_level(useB, 1'b0, n);
    wait_level(useB, 1'b1, n);
    wait_level(useB, 1'b0, w);
    wait_level(useB, 1'b1, n);
    p = w + n;
  endtask

  task automatic watch_quiet(input int cycles, input logic withPump, output logic any);
    any = 1'b0;
    repeat (cycles) begin
      @(negedge clk_sys);
      any = any | monitorA | monitorB | (withPump & (pumpSink | pumpSource));
    end
  endtask

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    check("pumpGain reset", 16'(pumpGain), 16'h0003);
    check("pumpFactorX10 reset", 16'(pumpFactorX10), 16'h0028);
    check("pump reset", 16'({pumpSink, pumpSource}), 16'h0000);
    for (int g = 0; g < 4; g++) begin
      load(14'h003b, 2'(g));
      check("pumpGain", 16'(pumpGain), 16'(g));
      check("pumpFactorX10", 16'(pumpFactorX10), 16'(factorExp[g]));
    end
    // bus moves while strobe is low
    @(posedge clk_sys);
    rfWord <= 14'h0000;
    pumpGainSelect <= 2'h0;
    repeat (4) @(posedge clk_sys);
    check("pumpGain held", 16'(pumpGain), 16'h0003);
    measure(1'b0, per, wid);
    check("rf period", 16'(per), 16'd236);
    check("rf width", 16'(wid), 16'd32);
    measure(1'b1, per, wid);
    check("ref period", 16'(per), 16'd30);
    check("ref width", 16'(wid), 16'd3);
    @(posedge clk_sys);
    loopSense <= 1'b0;
    measure(1'b1, per, wid);
    check("rf period swapped", 16'(per), 16'd236);
    measure(1'b0, per, wid);
    check("ref period swapped", 16'(per), 16'd30);
    // reference pulse arrives first after release, so it leads
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_sys);
      loopSense <= 1'(s);
      load(14'h003b, 2'h1);
      pumpSeen = 2'h0;
      for (int n = 0; n < 2000 && pumpSeen == 2'h0; n++) begin
        @(negedge clk_sys);
        pumpSeen = {pumpSink, pumpSource};
      end
      check("first pump", 16'(pumpSeen), (s == 1) ? 16'h0001 : 16'h0002);
    end
    // M=8 A=2 against R=44: rf starts 31 cycles late so both divided pulses land together
    @(posedge clk_sys);
    rfRun <= 1'b0;
    refRun <= 1'b0;
    refRatio <= 10'h02c;
    load(14'h0042, 2'h2);
    @(posedge clk_sys);
    refRun <= 1'b1;
    repeat (31) @(posedge clk_sys);
    rfRun <= 1'b1;
    pumpSeen = 2'h0;
    repeat (2800) begin
      @(negedge clk_sys);
      pumpSeen = pumpSeen | {pumpSink, pumpSource};
    end
    check("aligned pump", 16'(pumpSeen), 16'h0000);
    check("lock set", 16'(lockSink), 16'h0001);
    // strobe is seen at the next edge and the monitors lag one more
    @(posedge clk_sys);
    loadStrobe <= 1'b1;
    repeat (2) @(posedge clk_sys);
    watch_quiet(300, 1'b1, seenAny);
    check("held quiet", 16'(seenAny), 16'h0000);
    @(posedge clk_sys);
    loadStrobe <= 1'b0;
    dividedOutputEnable <= 1'b0;
    watch_quiet(300, 1'b0, seenAny);
    check("monitors off", 16'(seenAny), 16'h0000);
    check("lock unlocked", 16'(lockSink), 16'h0000);
    print_verdict();
  end
endmodule // tb_pll_div_ctrl
`default_nettype wire
